//--- rtl/ssp_pkg.sv
package ssp_pkg;
  // Register map
  localparam logic [12:0] ADDR_CTRL  = 13'h0000;
  localparam logic [12:0] ADDR_PART  = 13'h0001;
  localparam logic [12:0] ADDR_STAT  = 13'h0002;
  localparam logic [12:0] ADDR_PRS_H = 13'h0006;
  localparam logic [12:0] ADDR_PRS_M = 13'h0007;
  localparam logic [12:0] ADDR_PRS_L = 13'h0008;
  localparam logic [12:0] ADDR_TMP_H = 13'h0009;
  localparam logic [12:0] ADDR_TMP_L = 13'h000a;
  localparam logic [12:0] ADDR_CMD   = 13'h0030;
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  CMD_RST    = 8'h00;
  localparam logic [23:0] PRS_RST    = 24'h000000;
  localparam logic [15:0] TMP_RST    = 16'h0000;
  // Field positions
  localparam int CTRL_FOUR   = 7;
  localparam int CTRL_LSB    = 6;
  localparam int CTRL_SRST   = 5;
  localparam int CTRL_SRST_M = 2;
  localparam int CTRL_LSB_M  = 1;
  localparam int CTRL_FOUR_M = 0;
  localparam int CMD_SCO     = 3;
  localparam logic [7:0] SCO_MASK = 8'h08;
  localparam logic [2:0] MODE_TEMP  = 3'h0;
  localparam logic [2:0] MODE_PRESS = 3'h1;
  localparam logic [2:0] MODE_COMB  = 3'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h3;
  // Serial framing
  localparam logic [3:0] CNT_ZERO  = 4'h0;
  localparam logic [3:0] CNT_ONE   = 4'h1;
  localparam logic [3:0] HDR_LAST  = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  localparam logic [1:0] LEFT_NONE  = 2'h0;
  localparam int HDR_RW = 15;
  // Timing
  localparam real CLK_PERIOD_NS = 4.0;
  localparam real IDLE_STEP_MS  = 62.5;
  localparam int  IDLE_STEP_CYC =
    int'(IDLE_STEP_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  STEP_CNT_W    = 24;
  typedef enum logic [3:0]
  {
    CV_IDLE  = 4'h1,
    CV_TEMP  = 4'h2,
    CV_PRESS = 4'h4,
    CV_WAIT  = 4'h8
  } ssp_conv_type;
endpackage : ssp_pkg

//--- rtl/ssp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_sync
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_reg;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s1_reg <= {W{1'b0}};
      o_q    <= {W{1'b0}};
    end
    else
    begin
      s1_reg <= i_d;
      o_q    <= s1_reg;
    end
  end
endmodule : ssp_sync
`default_nettype wire

//--- rtl/ssp_conv.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_conv
  import ssp_pkg::*;
#(
  parameter int STEP_CYCLES = IDLE_STEP_CYC,
  parameter int CNT_W       = STEP_CNT_W
)
(
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // Control
  input  wire logic       i_start,
  input  wire logic       i_run,
  input  wire logic [2:0] i_mode,
  input  wire logic [3:0] i_idle_code,
  // Converter handshake
  input  wire logic       i_temp_done,
  input  wire logic       i_press_done,
  output logic            o_temp_req,
  output logic            o_press_req,
  output logic            o_cycle_done
);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
  localparam logic [CNT_W-1:0] STEP_ZERO = {CNT_W{1'b0}};
  localparam logic [3:0]       LEFT_ONE  = 4'h1;

  ssp_conv_type     state_reg;
  ssp_conv_type     state_next;
  logic [2:0]       mode_reg;
  logic [CNT_W-1:0] step_reg;
  logic [3:0]       left_reg;
  logic             go;
  logic             legal;
  logic             temp_fin;
  logic             press_fin;
  logic             only_temp;
  logic             again;
  logic             step_end;
  logic             wait_end;
  logic             cycle_end;

  assign go        = (state_reg == CV_IDLE) && i_start;
  assign legal     = i_mode <= MODE_SLEEP;
  assign temp_fin  = (state_reg == CV_TEMP) && i_temp_done;
  assign press_fin = (state_reg == CV_PRESS) && i_press_done;
  assign only_temp = mode_reg == MODE_TEMP;
  assign again     = (mode_reg == MODE_SLEEP) && i_run;
  assign step_end  = step_reg == STEP_ZERO;
  assign wait_end  = (state_reg == CV_WAIT) && step_end &&
                     (left_reg == LEFT_ONE);
  // Codes above the periodic mode finish at once and start nothing
  assign cycle_end = press_fin || (temp_fin && only_temp) ||
                     (go && !legal);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      CV_IDLE:
        if (go && legal)
          state_next = (i_mode == MODE_PRESS) ? CV_PRESS : CV_TEMP;
      CV_TEMP:
        if (temp_fin)
          state_next = only_temp ? CV_IDLE : CV_PRESS;
      CV_PRESS:
        if (press_fin)
          state_next = !again ? CV_IDLE :
                       (i_idle_code == 4'h0) ? CV_TEMP : CV_WAIT;
      CV_WAIT:
        if (!i_run)
          state_next = CV_IDLE;
        else if (wait_end)
          state_next = CV_TEMP;
      default:
        state_next = CV_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_reg    <= CV_IDLE;
      mode_reg     <= MODE_TEMP;
      step_reg     <= STEP_ZERO;
      left_reg     <= 4'h0;
      o_temp_req   <= 1'b0;
      o_press_req  <= 1'b0;
      o_cycle_done <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      mode_reg     <= go ? i_mode : mode_reg;
      o_temp_req   <= (state_next == CV_TEMP) && (state_reg != CV_TEMP);
      o_press_req  <= (state_next == CV_PRESS) && (state_reg != CV_PRESS);
      o_cycle_done <= cycle_end;
      if ((state_next == CV_WAIT) && (state_reg != CV_WAIT))
      begin
        step_reg <= STEP_LAST;
        left_reg <= i_idle_code;
      end
      else if ((state_reg == CV_WAIT) && step_end)
      begin
        step_reg <= STEP_LAST;
        left_reg <= left_reg - LEFT_ONE;
      end
      else if (state_reg == CV_WAIT)
        step_reg <= step_reg - CNT_W'(1);
    end
  end
endmodule : ssp_conv
`default_nettype wire

//--- rtl/ssp_top.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_top
  import ssp_pkg::*;
#(
  parameter int IDLE_STEP_CYCLES = IDLE_STEP_CYC,
  parameter int CNT_W            = STEP_CNT_W
)
(
  // System clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  // Serial link
  input  wire logic        i_sclk,
  input  wire logic        i_csb_n,
  input  wire logic        i_sdio_in,
  output logic             o_sdio_out,
  output logic             o_sdio_oe_n,
  output logic             o_sdo_out,
  output logic             o_sdo_oe_n,
  // Converter handshake
  output logic             o_temp_req,
  output logic             o_press_req,
  input  wire logic        i_temp_done,
  input  wire logic        i_press_done,
  input  wire logic [15:0] i_temp_data,
  input  wire logic [23:0] i_press_data,
  // Diagnostics and identity
  input  wire logic        i_diag_en,
  input  wire logic [3:0]  i_fault,
  input  wire logic [7:0]  i_part_identifier_reg
);

  // Address step shared by the write and the read-ahead path
  function automatic logic [12:0] ssp_step(input logic [12:0] a,
                                           input logic        lsb);
    ssp_step = lsb ? a + 13'h0001 : a - 13'h0001;
  endfunction : ssp_step

  // System-side state
  logic        rst_all_n;
  logic        srst_reg;
  logic        lrst_reg;
  logic        four_reg;
  logic        four_next;
  logic        lsb_reg;
  logic        lsb_next;
  logic [7:0]  cmd_reg;
  logic [7:0]  cmd_next;
  logic        start_reg;
  logic        result_ready_flag_reg;
  logic        result_ready_flag_next;
  logic [23:0] prs_reg;
  logic [15:0] tmp_reg;
  logic [7:0]  rd_data_reg;
  logic [1:0]  tgl_s;
  logic [1:0]  tgl_q_reg;
  logic        wr_stb;
  logic        rd_stb;
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        srst_req;
  logic        sco_clr;
  logic        cycle_done;
  logic [3:0]  err;
  logic [7:0]  ctrl_rd;
  logic [7:0]  stat_rd;
  logic [7:0]  rd_word;

  // Link-side state
  logic        sel_clr;
  logic        active_reg;
  logic [1:0]  cfg_s1_reg;
  logic [1:0]  cfg_s2_reg;
  logic        lsb_l;
  logic        four_l;
  logic [3:0]  bcnt_reg;
  logic [3:0]  bcnt_next;
  logic [15:0] hdr_reg;
  logic [15:0] hdr_in;
  logic        hdr_done_reg;
  logic        live_reg;
  logic        live_next;
  logic        stream_reg;
  logic        rw_reg;
  logic [1:0]  left_reg;
  logic [1:0]  left_next;
  logic [12:0] addr_reg;
  logic [12:0] addr_next;
  logic [7:0]  sh_reg;
  logic [7:0]  byte_in;
  logic [12:0] wr_addr_reg;
  logic [7:0]  wr_data_reg;
  logic        wr_tgl_reg;
  logic [12:0] rd_addr_reg;
  logic        rd_tgl_reg;
  logic        fresh;
  logic        resume;
  logic        new_frame;
  logic        in_hdr;
  logic        hdr_end;
  logic        in_data;
  logic        byte_end;
  logic        more;
  logic        wr_go;
  logic        rd_go;
  logic        drive;
  logic        load;
  logic [7:0]  tx_reg;
  logic [7:0]  tx_next;
  logic        dout_reg;
  logic        sdio_oe_n_reg;
  logic        sdo_oe_n_reg;

  // System domain: reset, crossings and register bank

  assign rst_all_n = i_rst_n && !srst_reg;

  // Link logic is reset from a flop so its asynchronous reset is clean
  always_ff @(posedge i_mclk)
  begin
    if (!rst_all_n)
      lrst_reg <= 1'b0;
    else
      lrst_reg <= 1'b1;
  end

  // Write and read requests arrive as toggles; address and data words
  // stay still until the next toggle, so only the toggles need syncing
  ssp_sync
  #(
    .W (2)
  )
  u_tgl_sync
  (
    .i_clk   (i_mclk),
    .i_rst_n (rst_all_n),
    .i_d     ({rd_tgl_reg, wr_tgl_reg}),
    .o_q     (tgl_s)
  );

  assign wr_stb   = tgl_s[0] ^ tgl_q_reg[0];
  assign rd_stb   = tgl_s[1] ^ tgl_q_reg[1];
  assign wr_ctrl  = wr_stb && (wr_addr_reg == ADDR_CTRL);
  assign wr_cmd   = wr_stb && (wr_addr_reg == ADDR_CMD);
  assign srst_req = wr_ctrl &&
                    (wr_data_reg[CTRL_SRST] || wr_data_reg[CTRL_SRST_M]);
  assign four_next = wr_ctrl ? (wr_data_reg[CTRL_FOUR] ||
                                wr_data_reg[CTRL_FOUR_M]) : four_reg;
  assign lsb_next  = wr_ctrl ? (wr_data_reg[CTRL_LSB] ||
                                wr_data_reg[CTRL_LSB_M]) : lsb_reg;
  assign sco_clr   = cycle_done &&
                     (cmd_reg[2:0] != MODE_SLEEP);
  // A write in the same cycle as the end of conversion keeps the write
  assign cmd_next  = wr_cmd ? wr_data_reg :
                     sco_clr ? (cmd_reg & ~SCO_MASK) : cmd_reg;
  // Set wins over the clear at a new start
  assign result_ready_flag_next = cycle_done || (result_ready_flag_reg && !start_reg);

  assign err     = i_diag_en ? i_fault : 4'h0;
  assign ctrl_rd = {four_reg, lsb_reg, srst_reg, 2'b00,
                    srst_reg, lsb_reg, four_reg};
  assign stat_rd = {1'b0, err, 1'b0, 1'b0, result_ready_flag_reg};
  assign rd_word = (rd_addr_reg == ADDR_CTRL)  ? ctrl_rd :
                   (rd_addr_reg == ADDR_PART)  ? i_part_identifier_reg :
                   (rd_addr_reg == ADDR_STAT)  ? stat_rd :
                   (rd_addr_reg == ADDR_PRS_H) ? prs_reg[23:16] :
                   (rd_addr_reg == ADDR_PRS_M) ? prs_reg[15:8] :
                   (rd_addr_reg == ADDR_PRS_L) ? prs_reg[7:0] :
                   (rd_addr_reg == ADDR_TMP_H) ? tmp_reg[15:8] :
                   (rd_addr_reg == ADDR_TMP_L) ? tmp_reg[7:0] :
                   (rd_addr_reg == ADDR_CMD)   ? cmd_reg :
                   8'h00;

  // Soft reset lasts one cycle; the port control bit reads back clear
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      srst_reg <= 1'b0;
    else
      srst_reg <= srst_req;
  end

  always_ff @(posedge i_mclk)
  begin
    if (!rst_all_n)
    begin
      tgl_q_reg   <= 2'b00;
      four_reg    <= CTRL_RST[CTRL_FOUR];
      lsb_reg     <= CTRL_RST[CTRL_LSB];
      cmd_reg     <= CMD_RST;
      start_reg   <= 1'b0;
      result_ready_flag_reg    <= 1'b0;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      tgl_q_reg   <= tgl_s;
      four_reg    <= four_next;
      lsb_reg     <= lsb_next;
      cmd_reg     <= cmd_next;
      start_reg   <= wr_cmd && wr_data_reg[CMD_SCO];
      result_ready_flag_reg    <= result_ready_flag_next;
      rd_data_reg <= rd_stb ? rd_word : rd_data_reg;
    end
  end

  // Results are held until the next conversion overwrites them
  always_ff @(posedge i_mclk)
  begin
    if (!rst_all_n)
    begin
      prs_reg <= PRS_RST;
      tmp_reg <= TMP_RST;
    end
    else
    begin
      prs_reg <= i_press_done ? i_press_data : prs_reg;
      tmp_reg <= i_temp_done ? i_temp_data : tmp_reg;
    end
  end

  ssp_conv
  #(
    .STEP_CYCLES (IDLE_STEP_CYCLES),
    .CNT_W       (CNT_W)
  )
  u_conv
  (
    .i_mclk       (i_mclk),
    .i_rst_n      (rst_all_n),
    .i_start      (start_reg),
    .i_run        (cmd_reg[CMD_SCO]),
    .i_mode       (cmd_reg[2:0]),
    .i_idle_code  (cmd_reg[7:4]),
    .i_temp_done  (i_temp_done),
    .i_press_done (i_press_done),
    .o_temp_req   (o_temp_req),
    .o_press_req  (o_press_req),
    .o_cycle_done (cycle_done)
  );

  // Link domain: runs on serial clock edges; link reset clears it at once, deselect clears only the select flag and the drivers

  // Deselect ends the select period at once, clock or no clock
  assign sel_clr = i_csb_n || !lrst_reg;

  always_ff @(posedge i_sclk or posedge sel_clr)
  begin
    if (sel_clr)
      active_reg <= 1'b0;
    else
      active_reg <= 1'b1;
  end

  always_ff @(posedge i_sclk or negedge lrst_reg)
  begin
    if (!lrst_reg)
    begin
      cfg_s1_reg <= 2'b00;
      cfg_s2_reg <= 2'b00;
    end
    else
    begin
      cfg_s1_reg <= {lsb_reg, four_reg};
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  assign lsb_l  = cfg_s2_reg[1];
  assign four_l = cfg_s2_reg[0];

  // A pause is legal only on a byte boundary of a short transfer
  assign fresh     = !active_reg;
  assign resume    = fresh && (bcnt_reg == CNT_ZERO) && hdr_done_reg &&
                     live_reg && !stream_reg;
  assign new_frame = fresh && !resume;
  assign in_hdr    = new_frame || !hdr_done_reg;
  assign hdr_in    = lsb_l ? {i_sdio_in, hdr_reg[15:1]} :
                             {hdr_reg[14:0], i_sdio_in};
  assign hdr_end   = !new_frame && !hdr_done_reg &&
                     (bcnt_reg == HDR_LAST);
  assign in_data   = !new_frame && hdr_done_reg && live_reg;
  assign byte_in   = lsb_l ? {i_sdio_in, sh_reg[7:1]} :
                             {sh_reg[6:0], i_sdio_in};
  assign byte_end  = in_data && (bcnt_reg == BYTE_LAST);
  assign more      = stream_reg || (left_reg != LEFT_NONE);

  assign bcnt_next = new_frame ? CNT_ONE :
                     (hdr_end || byte_end) ? CNT_ZERO :
                     (in_hdr || in_data) ? bcnt_reg + CNT_ONE : bcnt_reg;
  assign live_next = new_frame ? 1'b0 :
                     hdr_end ? 1'b1 :
                     (byte_end && !more) ? 1'b0 : live_reg;
  assign left_next = hdr_end ? hdr_in[14:13] :
                     (byte_end && !stream_reg && more) ?
                     left_reg - 2'h1 : left_reg;
  assign addr_next = hdr_end ? hdr_in[12:0] :
                     byte_end ? ssp_step(addr_reg, lsb_l) : addr_reg;
  assign wr_go     = byte_end && !rw_reg;
  assign rd_go     = (hdr_end && hdr_in[HDR_RW]) ||
                     (byte_end && rw_reg && more);

  always_ff @(posedge i_sclk or negedge lrst_reg)
  begin
    if (!lrst_reg)
    begin
      bcnt_reg     <= CNT_ZERO;
      hdr_reg      <= 16'h0000;
      hdr_done_reg <= 1'b0;
      live_reg     <= 1'b0;
      stream_reg   <= 1'b0;
      rw_reg       <= 1'b0;
      left_reg     <= LEFT_NONE;
      addr_reg     <= 13'h0000;
      sh_reg       <= 8'h00;
    end
    else
    begin
      bcnt_reg     <= bcnt_next;
      hdr_reg      <= in_hdr ? hdr_in : hdr_reg;
      hdr_done_reg <= new_frame ? 1'b0 : (hdr_end || hdr_done_reg);
      live_reg     <= live_next;
      stream_reg   <= hdr_end ? (hdr_in[14:13] == LEN_STREAM) :
                      stream_reg;
      rw_reg       <= hdr_end ? hdr_in[HDR_RW] : rw_reg;
      left_reg     <= left_next;
      addr_reg     <= addr_next;
      sh_reg       <= in_data ? byte_in : sh_reg;
    end
  end

  // Words toward the system side, each announced by a toggle
  always_ff @(posedge i_sclk or negedge lrst_reg)
  begin
    if (!lrst_reg)
    begin
      wr_addr_reg <= 13'h0000;
      wr_data_reg <= 8'h00;
      wr_tgl_reg  <= 1'b0;
      rd_addr_reg <= 13'h0000;
      rd_tgl_reg  <= 1'b0;
    end
    else
    begin
      wr_addr_reg <= wr_go ? addr_reg : wr_addr_reg;
      wr_data_reg <= wr_go ? byte_in : wr_data_reg;
      wr_tgl_reg  <= wr_tgl_reg ^ wr_go;
      rd_addr_reg <= rd_go ? addr_next : rd_addr_reg;
      rd_tgl_reg  <= rd_tgl_reg ^ rd_go;
    end
  end

  // Read data is fetched half a serial clock before it is shifted out;
  // the system clock must give at least three cycles in that half period
  assign drive   = hdr_done_reg && live_reg && rw_reg;
  assign load    = drive && (bcnt_reg == CNT_ZERO);
  assign tx_next = load ? rd_data_reg :
                   lsb_l ? {1'b0, tx_reg[7:1]} : {tx_reg[6:0], 1'b0};

  always_ff @(negedge i_sclk or negedge lrst_reg)
  begin
    if (!lrst_reg)
    begin
      tx_reg   <= 8'h00;
      dout_reg <= 1'b0;
    end
    else
    begin
      tx_reg   <= tx_next;
      dout_reg <= lsb_l ? tx_next[0] : tx_next[7];
    end
  end

  // After a pause the drivers come back at the first falling edge
  always_ff @(negedge i_sclk or posedge sel_clr)
  begin
    if (sel_clr)
    begin
      sdio_oe_n_reg <= 1'b1;
      sdo_oe_n_reg  <= 1'b1;
    end
    else
    begin
      sdio_oe_n_reg <= !(drive && !four_l);
      sdo_oe_n_reg  <= !(drive && four_l);
    end
  end

  assign o_sdio_out  = dout_reg;
  assign o_sdo_out   = dout_reg;
  assign o_sdio_oe_n = sdio_oe_n_reg;
  assign o_sdo_oe_n  = sdo_oe_n_reg;

endmodule : ssp_top
`default_nettype wire

//--- verif/ssp_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_chk
  import ssp_pkg::*;
#(
  parameter int IDLE_STEP_CYCLES = IDLE_STEP_CYC
)
(
  // Clocks, reset, link inputs and converter done
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_csb_n,
  input wire logic i_temp_done,
  // Watched outputs
  input wire logic o_sdio_out,
  input wire logic o_sdio_oe_n,
  input wire logic o_sdo_out,
  input wire logic o_sdo_oe_n,
  input wire logic o_temp_req,
  input wire logic o_press_req
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req_wait;
    o_temp_req ##1 !i_temp_done [*2];
  endsequence
  property p_oe_off;
    $past(i_csb_n) && i_csb_n |-> o_sdio_oe_n && o_sdo_oe_n;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe deselected");
  property p_oe_excl;
    o_sdio_oe_n || o_sdo_oe_n;
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both oe");
  property p_same_bit;
    o_sdio_out == o_sdo_out;
  endproperty
  a_same_bit: assert property (p_same_bit) else $error("outs differ");
  property p_pulse;
    o_temp_req || o_press_req |=> !o_temp_req && !o_press_req;
  endproperty
  a_pulse: assert property (p_pulse) else $error("req too long");
  property p_req_excl;
    !(o_temp_req && o_press_req);
  endproperty
  a_req_excl: assert property (p_req_excl) else $error("two reqs");
  property p_rst_quiet;
    $rose(i_rst_n) |-> o_sdio_oe_n && o_sdo_oe_n && !o_temp_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("not idle");
  property p_data_fall;
    !o_sdo_oe_n && $changed(o_sdo_out) |-> !i_sclk;
  endproperty
  a_data_fall: assert property (p_data_fall) else $error("late bit");
  property p_wait_done;
    s_req_wait |-> !o_press_req && !o_temp_req;
  endproperty
  a_wait_done: assert property (p_wait_done) else $error("no wait");
endmodule : ssp_chk
bind ssp_top ssp_chk #(.IDLE_STEP_CYCLES(IDLE_STEP_CYCLES)) u_ssp_chk
(
  .i_mclk      (i_mclk),
  .i_rst_n     (i_rst_n),
  .i_sclk      (i_sclk),
  .i_csb_n     (i_csb_n),
  .i_temp_done (i_temp_done),
  .o_sdio_out  (o_sdio_out),
  .o_sdio_oe_n (o_sdio_oe_n),
  .o_sdo_out   (o_sdo_out),
  .o_sdo_oe_n  (o_sdo_oe_n),
  .o_temp_req  (o_temp_req),
  .o_press_req (o_press_req)
);
`default_nettype wire

//--- verif/ssp_master.sv
`timescale 1ns/100ps
`default_nettype none
module ssp_master
(
  // Device read drivers
  input  wire logic i_sdio_out,
  input  wire logic i_sdio_oe_n,
  input  wire logic i_sdo_out,
  input  wire logic i_sdo_oe_n,
  // Link pins
  output logic      o_sclk,
  output logic      o_csb_n,
  output wire logic o_sdio
);
  logic drv, mbit, lsb, four, last;
  // Released line shows the inverse of its last level
  assign o_sdio = drv ? mbit : (i_sdio_oe_n ? ~last : i_sdio_out);
  initial
  begin
    o_sclk = 1'h0;
    o_csb_n = 1'h1;
    {drv, mbit, lsb, four, last} = 5'h10;
  end
  always @(posedge o_sclk)
    last <= o_sdio;
  // Clock rests low between pulses; the idle task also pulses it outside frames
  task automatic clk(input logic b, output logic r);
    mbit = b;
    #40 o_sclk = 1'h1;
    r = four ? (i_sdo_oe_n ? ~last : i_sdo_out) : o_sdio;
    #40 o_sclk = 1'h0;
  endtask : clk
  task automatic idle(input int n);
    logic b;
    for (int i = 0; i < n; i++)
      clk(mbit, b);
  endtask : idle
  task automatic xfer(input logic w, input logic [1:0] l,
                      input logic [12:0] a, input int n,
                      input logic [31:0] wd, output logic [31:0] q);
    logic [15:0] h;
    logic        b;
    int          k;
    h = {w, l, a};
    q = 32'h0;
    #7.3 o_csb_n = 1'h0;
    for (int i = 0; i < 16; i++)
      clk(h[lsb ? i : 15 - i], b);
    drv = !w;
    for (int i = 0; i < n; i++)
    begin
      k = 8 * (i / 8) + (lsb ? i % 8 : 7 - i % 8);
      clk(wd[k], b);
      q[k] = b;
    end
    #20 o_csb_n = 1'h1;
    drv = 1'h1;
    #60;
  endtask : xfer
  // Second part of a short write that paused on a byte boundary
  task automatic resume(input int n, input logic [31:0] wd);
    logic b;
    #7.3 o_csb_n = 1'h0;
    for (int i = 0; i < n; i++)
      clk(wd[lsb ? i : 7 - i], b);
    #20 o_csb_n = 1'h1;
    #60;
  endtask : resume
endmodule : ssp_master
`default_nettype wire

//--- verif/test_ssp_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_ssp_top;
  logic        i_mclk, i_rst_n, i_temp_done, i_press_done, i_diag_en;
  wire logic   i_sclk, i_csb_n, i_sdio_in;
  logic        o_sdio_out, o_sdio_oe_n, o_sdo_out, o_sdo_oe_n;
  logic        o_temp_req, o_press_req;
  logic [15:0] tdat;
  logic [23:0] pdat;
  logic [31:0] r;
  int          err_count, n_checks, n_t, n_p, tc, pc, m;
  ssp_top #(.IDLE_STEP_CYCLES(8)) u_ssp_top
  (
    .i_mclk       (i_mclk),
    .i_rst_n      (i_rst_n),
    .i_sclk       (i_sclk),
    .i_csb_n      (i_csb_n),
    .i_sdio_in    (i_sdio_in),
    .o_sdio_out   (o_sdio_out),
    .o_sdio_oe_n  (o_sdio_oe_n),
    .o_sdo_out    (o_sdo_out),
    .o_sdo_oe_n   (o_sdo_oe_n),
    .o_temp_req   (o_temp_req),
    .o_press_req  (o_press_req),
    .i_temp_done  (i_temp_done),
    .i_press_done (i_press_done),
    .i_temp_data  (tdat),
    .i_press_data (pdat),
    .i_diag_en    (i_diag_en),
    .i_fault      (4'ha),
    .i_part_identifier_reg    (8'h5a)
  );
  ssp_master u_ssp_master
  (
    .i_sdio_out  (o_sdio_out),
    .i_sdio_oe_n (o_sdio_oe_n),
    .i_sdo_out   (o_sdo_out),
    .i_sdo_oe_n  (o_sdo_oe_n),
    .o_sclk      (i_sclk),
    .o_csb_n     (i_csb_n),
    .o_sdio      (i_sdio_in)
  );
  initial
  begin
    i_mclk = 1'h0;
    forever #2 i_mclk = ~i_mclk;
  end
  // Converter answers each request a few cycles later
  always @(negedge i_mclk)
  begin
    i_temp_done <= tc == 1;
    i_press_done <= pc == 1;
    tc <= o_temp_req ? 5 : (tc > 0 ? tc - 1 : 0);
    pc <= o_press_req ? 5 : (pc > 0 ? pc - 1 : 0);
  end
  always @(posedge i_mclk)
  begin
    n_t <= n_t + o_temp_req;
    n_p <= n_p + o_press_req;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [12:0] a, input logic [1:0] l, input int n,
          input logic [31:0] e);
    u_ssp_master.xfer(1'h1, l, a, 8 * n, 32'h0, r);
    chk(r, e);
  endtask : rd
  task wr(input logic [12:0] a, input logic [7:0] d);
    u_ssp_master.xfer(1'h0, 2'h0, a, 8, {24'h0, d}, r);
  endtask : wr
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    #300000;
    err_count++;
    test_done;
  end
  initial
  begin
    {i_rst_n, i_temp_done, i_press_done, i_diag_en} = 4'h1;
    {tc, pc, n_t, n_p, err_count, n_checks} = '0;
    tdat = 16'h1234;
    pdat = 24'habcdef;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk) i_rst_n = 1'h1;
    repeat (4) @(negedge i_mclk);
    rd(13'h02, 2'h2, 3, 32'h005a50);
    rd(13'h0a, 2'h3, 4, 32'h0);
    rd(13'h05, 2'h0, 1, 32'h0);
    u_ssp_master.xfer(1'h0, 2'h0, 13'h30, 4, 32'hf0, r);
    rd(13'h30, 2'h0, 1, 32'h0);
    u_ssp_master.xfer(1'h0, 2'h1, 13'h31, 8, 32'h0, r);
    u_ssp_master.resume(8, 32'h50);
    rd(13'h30, 2'h0, 1, 32'h50);
    $display("test reset done");
    @(negedge i_mclk) i_diag_en = 1'h0;
    wr(13'h30, 8'h08);
    @(negedge i_mclk) tdat = 16'h5678;
    rd(13'h30, 2'h0, 1, 32'h0);
    rd(13'h02, 2'h0, 1, 32'h01);
    chk({n_t[15:0], n_p[15:0]}, 32'h00010000);
    wr(13'h30, 8'h09);
    rd(13'h0a, 2'h3, 4, 32'hcdef1234);
    @(negedge i_mclk) pdat = 24'h13579b;
    wr(13'h30, 8'h0a);
    rd(13'h0a, 2'h3, 4, 32'h579b5678);
    chk({n_t[15:0], n_p[15:0]}, 32'h00020002);
    // Undefined mode: no request, start bit drops at once
    wr(13'h30, 8'h0c);
    rd(13'h30, 2'h0, 1, 32'h04);
    chk({n_t[15:0], n_p[15:0]}, 32'h00020002);
    $display("test single done");
    wr(13'h30, 8'h1b);
    rd(13'h30, 2'h0, 1, 32'h1b);
    chk(32'(n_t > 12), 32'h1);
    wr(13'h30, 8'h13);
    rd(13'h30, 2'h0, 1, 32'h13);
    m = n_t;
    rd(13'h02, 2'h0, 1, 32'h01);
    chk(n_t, m);
    $display("test periodic done");
    wr(13'h00, 8'hc3);
    u_ssp_master.idle(4);
    {u_ssp_master.lsb, u_ssp_master.four} = 2'h3;
    rd(13'h06, 2'h2, 3, 32'h009b5713);
    rd(13'h00, 2'h0, 1, 32'hc3);
    wr(13'h00, 8'h24);
    {u_ssp_master.lsb, u_ssp_master.four} = 2'h0;
    u_ssp_master.idle(4);
    rd(13'h00, 2'h0, 1, 32'h0);
    rd(13'h0a, 2'h3, 4, 32'h0);
    $display("test config done");
    test_done;
  end
endmodule : test_ssp_top
`default_nettype wire
